// ===== hdl/core_regs_pkg.sv
package core_regs_pkg;
    // ==========================================================
    // Widths
    localparam int DATA_W = 8;
    localparam int ADDR_W = 16;
    // ==========================================================
    // Reset values and fixed constants
    localparam logic [15:0] STACK_RESET = 16'h01FF;
    localparam logic [7:0] STACK_HIGH_FIXED = 8'h01;
    localparam logic [7:0] STACK_LOW_TOP = 8'hFF;
    localparam logic [7:0] FLAGS_RESET = 8'hE8;
    localparam logic [7:0] FLAGS_FIXED_ONES = 8'hE0;
    localparam logic [7:0] BYTE_ZERO = 8'h00;
    localparam logic [15:0] PC_RESET = 16'h0000;
    localparam logic [7:0] BYTE_ONE = 8'h01;
    // ==========================================================
    // Flag bit positions
    localparam int FLAG_C = 0;
    localparam int FLAG_Z = 1;
    localparam int FLAG_N = 2;
    localparam int FLAG_I = 3;
    localparam int FLAG_H = 4;
    // ==========================================================
    // Stack frame sizes
    localparam logic [2:0] IRQ_FRAME_BYTES = 3'h5;
    localparam logic [2:0] CALL_FRAME_BYTES = 3'h2;
    // ==========================================================
    // Register selectors
    typedef enum logic [2:0] {
        SEL_ACC = 3'h0,
        SEL_INDEX = 3'h1,
        SEL_FLAGS = 3'h2,
        SEL_STACK_LOW = 3'h3,
        SEL_PC_LOW = 3'h4,
        SEL_PC_HIGH = 3'h5
    } reg_sel_t;
    // Context save sequencer states
    typedef enum logic [5:0] {
        ST_IDLE = 6'b00_0001,
        ST_PUSH = 6'b00_0010,
        ST_POP = 6'b00_0100,
        ST_DONE = 6'b00_1000,
        ST_CALL = 6'b01_0000,
        ST_RET = 6'b10_0000
    } ctx_state_t;
endpackage : core_regs_pkg

// ===== hdl/stack_if.sv
`timescale 1ns/10ps
interface stack_if;
    logic push;
    logic pop;
    logic reload;
    logic [7:0] stack_low;
    modport owner (input push, input pop, input reload, output stack_low);
    modport user (output push, output pop, output reload, input stack_low);
endinterface : stack_if

// ===== hdl/stack_pointer.sv
`timescale 1ns/10ps
module stack_pointer
    import core_regs_pkg::*;
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic load_en,
    input wire logic [7:0] load_val,
    stack_if.owner bus
);
    // ==========================================================
    // Low byte only; high byte is hardwired by the register set
    logic [7:0] low_reg;
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            low_reg <= STACK_LOW_TOP;
        end else if (bus.reload) begin
            low_reg <= STACK_LOW_TOP;
        end else if (load_en) begin
            low_reg <= load_val;
        end else if (bus.push) begin
            // Wrap is silent by design; no overflow flag exists
            low_reg <= low_reg - BYTE_ONE;
        end else if (bus.pop) begin
            low_reg <= low_reg + BYTE_ONE;
        end
    end
    assign bus.stack_low = low_reg;
endmodule : stack_pointer

// ===== hdl/cpu_core_register_set.sv
`timescale 1ns/10ps
module cpu_core_register_set
    import core_regs_pkg::*;
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic wr_en,
    input wire logic [2:0] wr_sel,
    input wire logic [7:0] wr_data,
    input wire logic prefix,
    input wire logic instr_done,
    input wire logic pc_load,
    input wire logic [15:0] pc_next,
    input wire logic alu_wr,
    input wire logic [7:0] alu_result,
    input wire logic [4:0] alu_flags,
    input wire logic [4:0] alu_flags_mask,
    input wire logic rsp,
    input wire logic irq_enter,
    input wire logic irq_return,
    input wire logic call,
    input wire logic ret,
    input wire logic mask_set,
    input wire logic mask_clr,
    input wire logic [7:0] stack_rd_data,
    output logic [7:0] acc,
    output logic [7:0] index_sel,
    output logic [7:0] index_first,
    output logic [7:0] index_second,
    output logic [7:0] prog_counter_low,
    output logic [7:0] prog_counter_high,
    output logic [7:0] flags_word,
    output logic [15:0] stack_ptr,
    output logic stack_wr,
    output logic stack_rd,
    output logic [7:0] stack_wr_data,
    output logic ctx_busy
);
    // ==========================================================
    // Register storage
    logic [7:0] acc_reg;
    logic [7:0] xa_reg;
    logic [7:0] xb_reg;
    logic [15:0] pc_reg;
    logic [7:0] flags_reg;
    logic use_second_reg;
    ctx_state_t state_reg;
    logic [2:0] cnt_reg;
    stack_if stack_lines ();
    logic stack_load;

    // ==========================================================
    // Prefix latch: holds for exactly one following instruction
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            use_second_reg <= 1'b0;
        end else if (prefix) begin
            use_second_reg <= 1'b1;
        end else if (instr_done) begin
            use_second_reg <= 1'b0;
        end
    end

    // ==========================================================
    // Context sequencer; byte order pc low, pc high, index, acc, flags
    logic [2:0] frame_len;
    logic is_push;
    assign is_push = (state_reg == ST_PUSH) || (state_reg == ST_CALL);
    assign frame_len = (state_reg == ST_CALL || state_reg == ST_RET) ?
        CALL_FRAME_BYTES : IRQ_FRAME_BYTES;
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state_reg <= ST_IDLE;
            cnt_reg <= 3'h0;
        end else begin
            case (state_reg)
                ST_IDLE: begin
                    cnt_reg <= 3'h0;
                    if (irq_enter) begin
                        state_reg <= ST_PUSH;
                    end else if (irq_return) begin
                        state_reg <= ST_POP;
                    end else if (call) begin
                        state_reg <= ST_CALL;
                    end else if (ret) begin
                        state_reg <= ST_RET;
                    end
                end
                ST_PUSH, ST_POP, ST_CALL, ST_RET: begin
                    if (cnt_reg == frame_len - 3'h1) begin
                        state_reg <= ST_DONE;
                    end
                    cnt_reg <= cnt_reg + 3'h1;
                end
                ST_DONE: begin
                    state_reg <= ST_IDLE;
                end
                default: begin
                    state_reg <= ST_IDLE;
                end
            endcase
        end
    end
    // Pop order is the reverse: index into frame from the top
    logic [2:0] pop_slot;
    assign pop_slot = frame_len - 3'h1 - cnt_reg;
    logic popping;
    assign popping = (state_reg == ST_POP) || (state_reg == ST_RET);
    assign stack_wr = is_push;
    assign stack_rd = popping;
    // Flags as they stood at entry, so the return restores the old mask
    logic [7:0] flags_saved_reg;
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            flags_saved_reg <= FLAGS_RESET;
        end else if (irq_enter && state_reg == ST_IDLE) begin
            flags_saved_reg <= flags_reg;
        end
    end
    always_comb begin
        case (cnt_reg)
            3'h0: stack_wr_data = pc_reg[7:0];
            3'h1: stack_wr_data = pc_reg[15:8];
            3'h2: stack_wr_data = xa_reg;
            3'h3: stack_wr_data = acc_reg;
            default: stack_wr_data = flags_saved_reg;
        endcase
    end
    // Pop increments after reading; stack owner sees the address before the increment
    assign stack_lines.push = is_push;
    assign stack_lines.pop = popping;
    assign stack_lines.reload = rsp;
    assign stack_load = wr_en && (wr_sel == SEL_STACK_LOW);
    stack_pointer stack_pointer_i (
        .clk(clk),
        .resetn(resetn),
        .load_en(stack_load),
        .load_val(wr_data),
        .bus(stack_lines)
    );

    // ==========================================================
    // Accumulator and index registers, no reset by intent
    logic wr_index;
    assign wr_index = wr_en && (wr_sel == SEL_INDEX);
    always_ff @(posedge clk) begin
        if (popping && (state_reg == ST_POP) && pop_slot == 3'h3) begin
            acc_reg <= stack_rd_data;
        end else if (alu_wr) begin
            acc_reg <= alu_result;
        end else if (wr_en && wr_sel == SEL_ACC) begin
            acc_reg <= wr_data;
        end
    end
    always_ff @(posedge clk) begin
        if ((state_reg == ST_POP) && pop_slot == 3'h2) begin
            xa_reg <= stack_rd_data;
        end else if (wr_index && !use_second_reg) begin
            xa_reg <= wr_data;
        end
    end
    // Second index is only ever written by software, never by the sequencer
    always_ff @(posedge clk) begin
        if (wr_index && use_second_reg) begin
            xb_reg <= wr_data;
        end
    end

    // ==========================================================
    // Program counter
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            pc_reg <= PC_RESET;
        end else if (popping && pop_slot == 3'h0) begin
            pc_reg[7:0] <= stack_rd_data;
        end else if (popping && pop_slot == 3'h1) begin
            pc_reg[15:8] <= stack_rd_data;
        end else if (pc_load) begin
            pc_reg <= pc_next;
        end else if (wr_en && wr_sel == SEL_PC_LOW) begin
            pc_reg[7:0] <= wr_data;
        end else if (wr_en && wr_sel == SEL_PC_HIGH) begin
            pc_reg[15:8] <= wr_data;
        end
    end

    // ==========================================================
    // Flags; hardware set of the mask wins over a software clear
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            flags_reg <= FLAGS_RESET;
        end else if (irq_enter && state_reg == ST_IDLE) begin
            flags_reg[FLAG_I] <= 1'b1;
        end else if ((state_reg == ST_POP) && pop_slot == 3'h4) begin
            flags_reg <= stack_rd_data | FLAGS_FIXED_ONES;
        end else if (mask_set) begin
            flags_reg[FLAG_I] <= 1'b1;
        end else if (mask_clr) begin
            flags_reg[FLAG_I] <= 1'b0;
        end else if (wr_en && wr_sel == SEL_FLAGS) begin
            flags_reg <= wr_data | FLAGS_FIXED_ONES;
        end else if (alu_wr) begin
            flags_reg[4:0] <= (flags_reg[4:0] & ~alu_flags_mask) |
                (alu_flags & alu_flags_mask);
        end
    end

    // ==========================================================
    // Outputs: visible on these ports; during a context push pc, first index, acc and entry flags also go out on stack_wr_data
    assign acc = acc_reg;
    assign index_first = xa_reg;
    assign index_second = xb_reg;
    assign index_sel = use_second_reg ? xb_reg : xa_reg;
    assign prog_counter_low = pc_reg[7:0];
    assign prog_counter_high = pc_reg[15:8];
    assign flags_word = flags_reg;
    assign stack_ptr = {STACK_HIGH_FIXED, stack_lines.stack_low};
    assign ctx_busy = (state_reg != ST_IDLE);

    // ==========================================================
    // Checks
    sequence s_irq_start;
        irq_enter && state_reg == ST_IDLE;
    endsequence
    property p_irq_five;
        @(posedge clk) disable iff (!resetn)
        s_irq_start |=> stack_wr [*5] ##1 !stack_wr;
    endproperty
    a_irq_five: assert property (p_irq_five) else $error("irq frame not 5");
    property p_call_two;
        @(posedge clk) disable iff (!resetn)
        (call && !irq_enter && !irq_return && state_reg == ST_IDLE) |=>
            stack_wr [*2] ##1 !stack_wr;
    endproperty
    a_call_two: assert property (p_call_two) else $error("call frame not 2");
    property p_pc_low_first;
        @(posedge clk) disable iff (!resetn)
        s_irq_start |=> stack_wr_data == prog_counter_low;
    endproperty
    a_pc_low_first: assert property (p_pc_low_first) else $error("pc low not first");
    property p_pushed_flags;
        @(posedge clk) disable iff (!resetn)
        s_irq_start |=> ##4 stack_wr_data == $past(flags_word, 5);
    endproperty
    a_pushed_flags: assert property (p_pushed_flags) else $error("flags push wrong");
    property p_mask_set;
        @(posedge clk) disable iff (!resetn)
        s_irq_start |=> flags_word[FLAG_I];
    endproperty
    a_mask_set: assert property (p_mask_set) else $error("mask not set");
    property p_stack_high;
        @(posedge clk) disable iff (!resetn)
        stack_ptr[15:8] == STACK_HIGH_FIXED;
    endproperty
    a_stack_high: assert property (p_stack_high) else $error("stack high moved");
    property p_push_dec;
        @(posedge clk) disable iff (!resetn)
        (stack_wr && !rsp && !stack_load) |=> stack_ptr[7:0] == $past(stack_ptr[7:0]) - 8'h01;
    endproperty
    a_push_dec: assert property (p_push_dec) else $error("push no dec");
    property p_second_kept;
        @(posedge clk) disable iff (!resetn)
        (ctx_busy && !wr_index) |=> $stable(index_second);
    endproperty
    a_second_kept: assert property (p_second_kept) else $error("second index moved");
    property p_prefix_sel;
        @(posedge clk) disable iff (!resetn)
        (prefix && !instr_done) ##1 !instr_done |-> index_sel == index_second;
    endproperty
    a_prefix_sel: assert property (p_prefix_sel) else $error("prefix ignored");
endmodule : cpu_core_register_set

// ===== sim/tb_top.sv
`timescale 1ns/10ps
module tb_top
    import core_regs_pkg::*;
;
    // ==========================================================
    // Stimulus and observed signals
    logic clk = 1'b0, resetn = 1'b0, wr_en = 1'b0, pc_load = 1'b0, alu_wr = 1'b0;
    logic prefix, instr_done, rsp, irq_enter, irq_return, call, ret, mask_set, mask_clr;
    logic [2:0] wr_sel = 3'h0;
    logic [7:0] wr_data = 8'h00, alu_result = 8'h00, stack_rd_data = 8'h00;
    logic [15:0] pc_next = 16'h0000;
    logic [4:0] alu_flags = 5'h00, alu_flags_mask = 5'h00;
    logic [7:0] acc, index_sel, index_first, index_second, prog_counter_low, prog_counter_high;
    logic [7:0] flags_word, stack_wr_data, a, x, y, f0;
    logic [15:0] stack_ptr, pc, seed = 16'h03C7;
    logic stack_wr, stack_rd, ctx_busy;
    logic [7:0] push_b [0:7];
    logic [7:0] pop_b [0:4];
    int err_total = 0, compares = 0, npush, npop;
    // Pulse order: prefix, irq_enter, irq_return, call, ret, rsp, mask_set, mask_clr, instr_done
    localparam logic [8:0] K_PRE = 9'h100, K_IRQ = 9'h080, K_IRET = 9'h040, K_CALL = 9'h020;
    localparam logic [8:0] K_RET = 9'h010, K_RSP = 9'h008, K_MSET = 9'h004, K_MCLR = 9'h002;
    localparam logic [8:0] K_DONE = 9'h001;
    initial
        {prefix, irq_enter, irq_return, call, ret, rsp, mask_set, mask_clr, instr_done} = 9'h000;
    always #50 clk = ~clk;
    assign pc = {prog_counter_high, prog_counter_low};

    cpu_core_register_set cpu_core_register_set_i (.clk(clk), .resetn(resetn), .wr_en(wr_en),
        .wr_sel(wr_sel), .wr_data(wr_data), .prefix(prefix), .instr_done(instr_done),
        .pc_load(pc_load), .pc_next(pc_next), .alu_wr(alu_wr), .alu_result(alu_result),
        .alu_flags(alu_flags), .alu_flags_mask(alu_flags_mask), .rsp(rsp),
        .irq_enter(irq_enter), .irq_return(irq_return), .call(call), .ret(ret),
        .mask_set(mask_set), .mask_clr(mask_clr), .stack_rd_data(stack_rd_data), .acc(acc),
        .index_sel(index_sel), .index_first(index_first), .index_second(index_second),
        .prog_counter_low(prog_counter_low), .prog_counter_high(prog_counter_high),
        .flags_word(flags_word), .stack_ptr(stack_ptr), .stack_wr(stack_wr),
        .stack_rd(stack_rd), .stack_wr_data(stack_wr_data), .ctx_busy(ctx_busy));

    // ==========================================================
    // Helpers
    function automatic logic [15:0] lfsr_next(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr_next

    function automatic logic [7:0] exp_flags(input logic [7:0] old, input logic [4:0] f,
                                             input logic [4:0] m);
        return (old & ~{3'h0, m}) | ({3'h0, f} & {3'h0, m});
    endfunction : exp_flags

    task automatic rnd(output logic [7:0] v);
        seed = lfsr_next(seed);
        v = seed[7:0];
    endtask : rnd

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            err_total++;
            $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic final_report();
        $display("compares %0d mismatches %0d", compares, err_total);
        if (err_total == 0 && compares > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : final_report

    task automatic strobe(input logic [8:0] m);
        {prefix, irq_enter, irq_return, call, ret, rsp, mask_set, mask_clr, instr_done} = m;
        @(negedge clk);
        {prefix, irq_enter, irq_return, call, ret, rsp, mask_set, mask_clr, instr_done} = 9'h000;
    endtask : strobe

    task automatic wr(input logic [2:0] sel, input logic [7:0] d);
        wr_en = 1'b1;
        wr_sel = sel;
        wr_data = d;
        @(negedge clk);
        wr_en = 1'b0;
        @(negedge clk);
    endtask : wr

    task automatic load_pc(input logic [15:0] v);
        pc_load = 1'b1;
        pc_next = v;
        @(negedge clk);
        pc_load = 1'b0;
    endtask : load_pc

    // Fixed span covers the longest frame; the pop line toggles when not read
    task automatic run_seq(input logic [8:0] m);
        npush = 0;
        npop = 0;
        strobe(m);
        repeat (12) begin
            if (stack_wr === 1'b1 && npush < 8) begin
                push_b[npush] = stack_wr_data;
                npush++;
            end
            if (stack_rd === 1'b1 && npop < 5) begin
                stack_rd_data = pop_b[npop];
                npop++;
            end else begin
                stack_rd_data = ~stack_rd_data;
            end
            @(negedge clk);
        end
        check({15'h0000, ctx_busy}, 16'h0000);
    endtask : run_seq

    // ==========================================================
    // Tests
    initial begin
        repeat (3000) @(posedge clk);
        err_total++;
        final_report();
    end

    initial begin
        repeat (16) @(posedge clk);
        @(negedge clk);
        resetn = 1'b1;
        check(pc, 16'h0000);
        check({8'h00, flags_word}, 16'h00E8);
        check(stack_ptr, 16'h01FF);
        $display("test reset done");
        repeat (4) begin
            rnd(a);
            rnd(x);
            rnd(y);
            wr(3'h0, a);
            wr(3'h1, x);
            check({8'h00, acc}, {8'h00, a});
            check({8'h00, index_first}, {8'h00, x});
            strobe(K_PRE);
            wr(3'h1, y);
            check({8'h00, index_second}, {8'h00, y});
            check({8'h00, index_sel}, {8'h00, y});
            strobe(K_DONE);
            check({index_first, index_sel}, {x, x});
            rnd(f0);
            alu_wr = 1'b1;
            alu_result = f0;
            alu_flags = seed[12:8];
            alu_flags_mask = seed[15:11] & 5'h17;
            a = exp_flags(flags_word, alu_flags, alu_flags_mask);
            @(negedge clk);
            alu_wr = 1'b0;
            check({acc, flags_word}, {f0, a});
            wr(3'h0, f0);
        end
        wr(3'h4, a);
        wr(3'h5, x);
        check(pc, {x, a});
        wr(3'h2, y);
        check({8'h00, flags_word}, {8'h00, y | FLAGS_FIXED_ONES});
        $display("test data registers done");
        strobe(K_MCLR);
        check({15'h0000, flags_word[FLAG_I]}, 16'h0000);
        @(negedge clk);
        strobe(K_MSET);
        check({15'h0000, flags_word[FLAG_I]}, 16'h0001);
        @(negedge clk);
        strobe(K_MCLR);
        load_pc({x, f0});
        a = f0;
        f0 = flags_word;
        run_seq(K_IRQ);
        check(npush[15:0], 16'h0005);
        check({push_b[0], push_b[1]}, {a, x});
        check({push_b[2], push_b[3]}, {x, a});
        check({8'h00, push_b[4]}, {8'h00, f0});
        check(stack_ptr, 16'h01FA);
        check({15'h0000, flags_word[FLAG_I]}, 16'h0001);
        check({8'h00, index_second}, {8'h00, y});
        $display("test interrupt entry done");
        for (int i = 0; i < 5; i++) rnd(pop_b[i]);
        wr(3'h0, ~pop_b[1]);
        wr(3'h1, ~pop_b[2]);
        run_seq(K_IRET);
        check(npop[15:0], 16'h0005);
        check({acc, index_first}, {pop_b[1], pop_b[2]});
        check(pc, {pop_b[3], pop_b[4]});
        check({8'h00, flags_word}, {8'h00, pop_b[0] | FLAGS_FIXED_ONES});
        check(stack_ptr, 16'h01FF);
        check({8'h00, index_second}, {8'h00, y});
        $display("test interrupt return done");
        wr(3'h3, 8'h00);
        run_seq(K_CALL);
        check(npush[15:0], 16'h0002);
        check({push_b[1], push_b[0]}, pc);
        check(stack_ptr, 16'h01FE);
        pop_b[0] = pc[15:8];
        pop_b[1] = pc[7:0];
        load_pc(16'h0000);
        run_seq(K_RET);
        check(pc, {pop_b[0], pop_b[1]});
        check(stack_ptr, 16'h0100);
        strobe(K_RSP);
        check(stack_ptr, 16'h01FF);
        $display("test call and wrap done");
        final_report();
    end
endmodule : tb_top
